/* File: hdl/bcsr_consts.svh */
`ifndef BCSR_CONSTS_SVH
`define BCSR_CONSTS_SVH
// Target identifier classes
`define BCSR_PT_ID_MAX 8'h0F
`define BCSR_BC_ID 8'hFF
// Status block word offsets
`define BCSR_SB_OFS_ID 4'h0
`define BCSR_SB_OFS_FLG 4'h4
`define BCSR_SB_OFS_R8 4'h8
`define BCSR_SB_OFS_RC 4'hC
// Byte positions in word 04H
`define BCSR_ERR_LSB 16
`define BCSR_FLG_LSB 24
// Flag bit positions
`define BCSR_FLG_ERR_BIT 6
`define BCSR_FLG_DONE_BIT 7
// Reset values
`define BCSR_RST_WORD 32'h0000_0000
`endif

/* File: hdl/bcsr_pkg.sv */
package bcsr_pkg;
    typedef enum logic [1:0] {
        BCSR_IDLE = 2'b00,
        BCSR_EXEC = 2'b01,
        BCSR_DONE = 2'b10
    } bcsr_state_t;
    typedef enum logic [1:0] {
        BCSR_CLS_NONE = 2'b00,
        BCSR_CLS_PT = 2'b01,
        BCSR_CLS_BC = 2'b10
    } bcsr_class_t;
endpackage

/* File: hdl/bcsr_top.sv */
`timescale 1ns/1ps
`include "bcsr_consts.svh"
// Operation
// - IDs 0..15 mean pass-through to address
// - ID FFH means board-control command
// - Report completion in general status layout
// - Four words: id, error/flags, two reserved
// - Echo command identifier into status block
// - Flags byte polled; bits 5..0 zero
// - Flags bit 6 set on error
// - Flags bit 7 set when finished
// - Device-detected error code into error byte
module bcsr_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Parameter block fetch
    input wire logic cmd_valid_i,
    input wire logic [31:0] cmd_ident_i,
    input wire logic [7:0] cmd_target_i,
    // Board-control execution result
    input wire logic exec_done_i,
    input wire logic exec_err_i,
    input wire logic [7:0] exec_err_code_i,
    // Classification
    output logic pt_start_o,
    output logic [3:0] pt_addr_o,
    output logic bc_start_o,
    output logic busy_o,
    // Status block write-back
    output logic sb_we_o,
    output logic [3:0] sb_ofs_o,
    output logic [31:0] sb_data_o,
    output logic command_done_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        bcsr_pkg::bcsr_state_t st;
        logic [31:0] ident;
        logic [7:0] err_code;
        logic err;
        logic [1:0] wcnt;
        logic pt_start;
        logic [3:0] pt_addr;
        logic bc_start;
        logic busy;
        logic sb_we;
        logic [3:0] sb_ofs;
        logic [31:0] sb_data;
        logic done_flag;
    } bcsr_regs_t;

    bcsr_regs_t q_r;
    bcsr_regs_t q_nxt;
    logic rst_n;

    assign rst_n = q_r.rst_s;

    function automatic bcsr_pkg::bcsr_class_t classify(input logic [7:0] tid);
        if (tid <= `BCSR_PT_ID_MAX) begin
            classify = bcsr_pkg::BCSR_CLS_PT;
        end else if (tid == `BCSR_BC_ID) begin
            classify = bcsr_pkg::BCSR_CLS_BC;
        end else begin
            classify = bcsr_pkg::BCSR_CLS_NONE;
        end
    endfunction

    function automatic logic [31:0] flag_word(input logic [7:0] code, input logic err,
                                              input logic done);
        logic [7:0] flg;
        flg = 8'h00;
        flg[`BCSR_FLG_ERR_BIT] = err;
        flg[`BCSR_FLG_DONE_BIT] = done;
        flag_word = {flg, code, 16'h0000};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        q_nxt = q_r;
        q_nxt.rst_m = 1'b1;
        q_nxt.rst_s = q_r.rst_m;
        q_nxt.pt_start = 1'b0;
        q_nxt.bc_start = 1'b0;
        q_nxt.sb_we = 1'b0;
        case (q_r.st)
            bcsr_pkg::BCSR_IDLE: begin
                if (cmd_valid_i) begin
                    case (classify(cmd_target_i))
                        bcsr_pkg::BCSR_CLS_PT: begin
                            q_nxt.pt_start = 1'b1;
                            q_nxt.pt_addr = cmd_target_i[3:0];
                        end
                        bcsr_pkg::BCSR_CLS_BC: begin
                            q_nxt.bc_start = 1'b1;
                            q_nxt.busy = 1'b1;
                            q_nxt.ident = cmd_ident_i;
                            q_nxt.done_flag = 1'b0;
                            q_nxt.st = bcsr_pkg::BCSR_EXEC;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            bcsr_pkg::BCSR_EXEC: begin
                if (exec_done_i) begin
                    q_nxt.err = exec_err_i;
                    q_nxt.err_code = exec_err_i ? exec_err_code_i : 8'h00;
                    q_nxt.wcnt = 2'h0;
                    q_nxt.st = bcsr_pkg::BCSR_DONE;
                end
            end
            bcsr_pkg::BCSR_DONE: begin
                // Words go out 00,08,0C then 04 last so completion lands last
                q_nxt.sb_we = 1'b1;
                q_nxt.wcnt = q_r.wcnt + 2'h1;
                case (q_r.wcnt)
                    2'h0: begin
                        q_nxt.sb_ofs = `BCSR_SB_OFS_ID;
                        q_nxt.sb_data = q_r.ident;
                    end
                    2'h1: begin
                        q_nxt.sb_ofs = `BCSR_SB_OFS_R8;
                        q_nxt.sb_data = `BCSR_RST_WORD;
                    end
                    2'h2: begin
                        q_nxt.sb_ofs = `BCSR_SB_OFS_RC;
                        q_nxt.sb_data = `BCSR_RST_WORD;
                    end
                    default: begin
                        q_nxt.sb_ofs = `BCSR_SB_OFS_FLG;
                        q_nxt.sb_data = flag_word(q_r.err_code, q_r.err, 1'b1);
                        q_nxt.done_flag = 1'b1;
                        q_nxt.busy = 1'b0;
                        q_nxt.st = bcsr_pkg::BCSR_IDLE;
                    end
                endcase
            end
            default: begin
                q_nxt.st = bcsr_pkg::BCSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= '0;
        end else if (!q_r.rst_s) begin
            q_r <= '0;
            q_r.rst_m <= q_nxt.rst_m;
            q_r.rst_s <= q_nxt.rst_s;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pt_start_o = q_r.pt_start;
    assign pt_addr_o = q_r.pt_addr;
    assign bc_start_o = q_r.bc_start;
    assign busy_o = q_r.busy;
    assign sb_we_o = q_r.sb_we;
    assign sb_ofs_o = q_r.sb_ofs;
    assign sb_data_o = q_r.sb_data;
    assign command_done_flag_o = q_r.done_flag;

    ////////////////////////////////////////////////////////////////////////
    AST_PT_CLASS: assert property (@(posedge clk_i) disable iff (!rst_n)
        (q_r.st == bcsr_pkg::BCSR_IDLE && cmd_valid_i && cmd_target_i <= 8'h0F)
        |=> (pt_start_o && pt_addr_o == $past(cmd_target_i[3:0])))
        else $error("Pass-through target not started");
    AST_BC_CLASS: assert property (@(posedge clk_i) disable iff (!rst_n)
        bc_start_o |-> $past(cmd_target_i) == 8'hFF)
        else $error("Board-control start without FFH");
    AST_SB_SEQ: assert property (@(posedge clk_i) disable iff (!rst_n)
        (q_r.st == bcsr_pkg::BCSR_EXEC && exec_done_i) |=> ##1 sb_we_o [*4])
        else $error("Status block not written as four words");
    AST_SB_OFS: assert property (@(posedge clk_i) disable iff (!rst_n)
        sb_we_o |-> sb_ofs_o inside {4'h0, 4'h4, 4'h8, 4'hC})
        else $error("Status word offset illegal");
    AST_ID_ECHO: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_we_o && sb_ofs_o == 4'h0) |-> sb_data_o == q_r.ident)
        else $error("Identifier not echoed");
    AST_FLG_LOW: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_we_o && sb_ofs_o == 4'h4) |-> sb_data_o[29:24] == 6'h00 && sb_data_o[15:0] == 16'h0)
        else $error("Reserved flag bits nonzero");
    AST_ERR_BIT: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_we_o && sb_ofs_o == 4'h4) |-> sb_data_o[30] == q_r.err)
        else $error("Error bit mismatch");
    AST_DONE_LAST: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(command_done_flag_o) |-> sb_we_o && sb_ofs_o == 4'h4 && sb_data_o[31])
        else $error("Completion without flag word");
    AST_ERR_CODE: assert property (@(posedge clk_i) disable iff (!rst_n)
        (q_r.st == bcsr_pkg::BCSR_EXEC && exec_done_i && exec_err_i)
        |=> ##4 sb_data_o[23:16] == $past(exec_err_code_i, 5))
        else $error("Error code not reported");
    AST_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_we_o && sb_ofs_o == 4'h4) |-> $past(sb_we_o, 3) && $past(sb_ofs_o, 3) == 4'h0)
        else $error("Identifier not written before flags");
    // Unknown classes and commands met while busy start nothing
    AST_NO_CLASS: assert property (@(posedge clk_i) disable iff (!rst_n)
        (q_r.st == bcsr_pkg::BCSR_IDLE && cmd_valid_i && cmd_target_i > 8'h0F
            && cmd_target_i != 8'hFF) |=> !pt_start_o && !bc_start_o)
        else $error("Unknown target class started");
    AST_BUSY_REFUSE: assert property (@(posedge clk_i) disable iff (!rst_n)
        (q_r.st != bcsr_pkg::BCSR_IDLE && cmd_valid_i)
        |=> !pt_start_o && !bc_start_o && $stable(q_r.ident))
        else $error("Command accepted while busy");
    AST_DONE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
        bc_start_o |-> !command_done_flag_o && busy_o)
        else $error("Completion flag not cleared on accept");
    COV_PT: cover property (@(posedge clk_i) disable iff (!rst_n) pt_start_o);
    COV_BC_OK: cover property (@(posedge clk_i) disable iff (!rst_n)
        command_done_flag_o && !q_r.err);
    COV_BC_ERR: cover property (@(posedge clk_i) disable iff (!rst_n)
        command_done_flag_o && q_r.err);
    COV_REFUSED: cover property (@(posedge clk_i) disable iff (!rst_n)
        q_r.st != bcsr_pkg::BCSR_IDLE && cmd_valid_i);
    COV_SB_BURST: cover property (@(posedge clk_i) disable iff (!rst_n) sb_we_o [*4]);
endmodule

/* File: verification/bcsr_host_model.sv */
`timescale 1ns/1ps
// Host memory that catches the status block words and notes their order
module bcsr_host_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Status write-back from the device
    input wire logic bc_start_i,
    input wire logic sb_we_i,
    input wire logic [3:0] sb_ofs_i,
    input wire logic [31:0] sb_data_i
);
    logic [31:0] sb_mem [4];
    logic [2:0] word_cnt;
    logic flag_last;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_cnt <= 3'h0;
            flag_last <= 1'b0;
            sb_mem <= '{default: 32'hFFFF_FFFF};
        end else if (bc_start_i) begin
            word_cnt <= 3'h0;
            flag_last <= 1'b0;
            sb_mem <= '{default: 32'hFFFF_FFFF};
        end else if (sb_we_i) begin
            sb_mem[sb_ofs_i[3:2]] <= sb_data_i;
            word_cnt <= word_cnt + 3'h1;
            // Flag word only counts as last when three words came first
            if (sb_ofs_i == 4'h4) begin
                flag_last <= (word_cnt == 3'h3);
            end
        end
    end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0;
    logic exec_done_i = 1'b0, exec_err_i = 1'b0;
    logic [31:0] cmd_ident_i = 32'h0, sb_data_o;
    logic [7:0] cmd_target_i = 8'h0, exec_err_code_i = 8'h0;
    logic pt_start_o, bc_start_o, busy_o, sb_we_o, command_done_flag_o, pt, bc;
    logic [3:0] pt_addr_o, sb_ofs_o;
    logic [7:0] tg [4] = '{8'h00, 8'h0F, 8'h10, 8'hFE};
    int num_errors = 0, samples_checked = 0;

    always #25 clk_i = ~clk_i;
    bcsr_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ident_i(cmd_ident_i), .cmd_target_i(cmd_target_i), .exec_done_i(exec_done_i),
        .exec_err_i(exec_err_i), .exec_err_code_i(exec_err_code_i), .pt_start_o(pt_start_o),
        .pt_addr_o(pt_addr_o), .bc_start_o(bc_start_o), .busy_o(busy_o), .sb_we_o(sb_we_o),
        .sb_ofs_o(sb_ofs_o), .sb_data_o(sb_data_o), .command_done_flag_o(command_done_flag_o));
    bcsr_host_model host_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .bc_start_i(bc_start_o),
        .sb_we_i(sb_we_o), .sb_ofs_i(sb_ofs_o), .sb_data_i(sb_data_o));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One-cycle command pulse, then watch for either start pulse
    task issue(input logic [7:0] tgt, input logic [31:0] id);
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_target_i = tgt;
        cmd_ident_i = id;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        pt = 1'b0;
        bc = 1'b0;
        repeat (3) begin
            pt = pt | pt_start_o;
            bc = bc | bc_start_o;
            @(negedge clk_i);
        end
    endtask
    task run_bc(input logic [31:0] id, input logic err, input logic [7:0] code,
                input logic [31:0] w4);
        int n;
        issue(8'hFF, id);
        chk("bc_start", 32'h1, {31'h0, bc});
        chk("busy", 32'h1, {31'h0, busy_o});
        chk("done_early", 32'h0, {31'h0, command_done_flag_o});
        issue(8'h03, ~id);
        chk("refused", 32'h0, {30'h0, pt, bc});
        exec_done_i = 1'b1;
        exec_err_i = err;
        exec_err_code_i = code;
        @(negedge clk_i);
        exec_done_i = 1'b0;
        n = 0;
        while (command_done_flag_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk("done_latency", 32'h4, n);
        chk("done_flag", 32'h1, {31'h0, command_done_flag_o});
        // Host copy of the flag word lands one edge after its strobe
        @(negedge clk_i);
        chk("word00", id, host_u.sb_mem[0]);
        chk("word04", w4, host_u.sb_mem[1]);
        chk("word08", 32'h0, host_u.sb_mem[2]);
        chk("word0C", 32'h0, host_u.sb_mem[3]);
        chk("flag_last", 32'h1, {31'h0, host_u.flag_last});
        chk("busy_end", 32'h0, {31'h0, busy_o});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 4; i++) begin
            issue(tg[i], 32'h0000_0100 + i);
            chk("pt_start", {31'h0, i < 2}, {31'h0, pt});
            chk("no_bc", 32'h0, {31'h0, bc});
            if (i < 2) chk("pt_addr", {28'h0, tg[i][3:0]}, {28'h0, pt_addr_o});
        end
        $display("test target classes done");
        run_bc(32'hA5C3_0001, 1'b0, 8'h55, 32'h8000_0000);
        $display("test good status done");
        run_bc(32'h5A3C_0002, 1'b1, 8'h3C, 32'hC03C_0000);
        $display("test error status done");
        @(negedge clk_i);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk("rst_done_flag", 32'h0, {31'h0, command_done_flag_o});
        chk("rst_busy", 32'h0, {31'h0, busy_o});
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        issue(8'h07, 32'h0000_0200);
        chk("pt_after_rst", 32'h1, {31'h0, pt});
        chk("pt_addr_after_rst", 32'h7, {28'h0, pt_addr_o});
        $display("test reset recovery done");
        conclude();
    end
    initial begin
        #(50 * 2000);
        num_errors++;
        conclude();
    end
endmodule
